// *** hdl/urg_pkg.sv ***
/*
  constants, field positions and state codes of the serial port register block.
  assumes byte-wide register file accesses at the offsets below.
*/
package urg_pkg;
  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] ADDR_DATA  = 12'hf40;
  localparam logic [11:0] ADDR_STAT0 = 12'hf41;
  localparam logic [11:0] ADDR_CTL0  = 12'hf42;
  localparam logic [11:0] ADDR_CTL1  = 12'hf43;
  localparam logic [11:0] ADDR_STAT1 = 12'hf44;
  localparam logic [7:0]  CTL_RESET  = 8'h00;
  // ------------------------------------------------------------------
  // control field positions
  // ------------------------------------------------------------------
  localparam int C0_TX_ON    = 7;
  localparam int C0_RX_ON    = 6;
  localparam int C0_FLOW     = 5;
  localparam int C0_PAR_ON   = 4;
  localparam int C0_PAR_ODD  = 3;
  localparam int C0_BREAK    = 2;
  localparam int C0_STOP2    = 1;
  localparam int C0_LOOP     = 0;
  localparam int C1_MODE_HI  = 7;
  localparam int C1_NINTH_ON = 6;
  localparam int C1_MODE_LO  = 5;
  localparam int C1_NINTH_TX = 4;
  localparam int C1_DE_POL   = 3;
  localparam int C1_TIMER    = 2;
  localparam int C1_MASK     = 1;
  localparam int C1_IR_ON    = 0;
  // ------------------------------------------------------------------
  // bit timing and receive buffer
  // ------------------------------------------------------------------
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_MID  = 4'h7;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [3:0] FRAME_MIN = 4'h9;
  localparam int FIFO_DEPTH = 8;
  localparam int RXW        = 14;
  localparam int W_IRQ      = 13;
  localparam int W_FRAME_START_FLAG   = 12;
  localparam int W_BRK      = 11;
  localparam int W_FE       = 10;
  localparam int W_PE       = 9;
  localparam int W_NINTH    = 8;
  // ------------------------------------------------------------------
  // state codes
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    URG_RX_IDLE  = 3'b000,
    URG_RX_START = 3'b001,
    URG_RX_DATA  = 3'b010,
    URG_RX_EXTRA = 3'b011,
    URG_RX_STOP  = 3'b100
  } urg_rx_e;
  typedef enum logic [0:0] {
    URG_TX_IDLE  = 1'b0,
    URG_TX_SHIFT = 1'b1
  } urg_tx_e;
endpackage : urg_pkg

// *** hdl/urg_uart.sv ***
/*
  serial port register block: register file, transmitter, receiver with an
  8-word receive buffer, address filter and baud divider.
  assumes all inputs are synchronous to sys_clk.
*/
// Behaviour
// - data writes transmit, data reads receive, one address
// - byte ready set on load, cleared by read
// - parity error flag, cleared by data read
// - overrun flag; read clears only when ready is 0
// - framing error on missing stop bit
// - break flag when whole character is zero
// - holding empty flag, cleared by data write
// - transmitter idle only when shifter finished
// - frame start flag on first frame data byte
// - received ninth bit, cleared by data read
// - separate transmit and receive enables, reset off
// - clear-to-send gates transmitter when flow control on
// - parity even/odd, one or two stop bits
// - force break drives serial output low unless loopback or infrared on, aborts frame
// - loopback feeds transmit line into receiver
// - address filter mode selects receive interrupts
// - ninth bit mode sends chosen ninth bit
// - driver enable polarity select
// - divider timer interrupt while receiver off, and live count readback
// - data interrupt mask keeps error interrupts
// - infrared routing of serial data
// - bit rate is clock over sixteen times divisor
// - address bytes compared against node address
`timescale 1ns/1ps

module urg_fifo #(
  parameter int W     = 14,
  parameter int DEPTH = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } urg_fifo_s;
  urg_fifo_s st;
  urg_fifo_s next_st;
  logic      push;
  logic      pop;

  assign in_ready  = st.cnt != (AW+1)'(DEPTH);
  assign out_valid = st.cnt != '0;
  assign out_data  = st.mem[st.rp];

  always_comb begin
    next_st = st;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp = st.wp + 1'h1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'h1;
    end
    next_st.cnt = st.cnt + {{AW{1'h0}}, push} - {{AW{1'h0}}, pop};
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : urg_fifo

module urg_uart (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  input  wire logic        cts_n,
  input  wire logic        ir_in_pin,
  output logic             ir_out_pin,
  output logic             transceiver_drive_output,
  input  wire logic [15:0] baud_divisor,
  input  wire logic [7:0]  node_address,
  output logic [15:0]      divider_count,
  output logic             rx_irq_request
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       ctl0;
    logic [7:0]       ctl1;
    logic [7:0]       rdata;
    logic [7:0]       thold;
    logic             transmit_holding_empty;
    urg_pkg::urg_tx_e tx_state;
    logic [11:0]      tx_shift;
    logic [3:0]       tx_left;
    logic [3:0]       tx_tick;
    logic             line;
    logic             so;
    logic             iro;
    logic             de;
    logic [15:0]      baud_divider;
    urg_pkg::urg_rx_e rx_state;
    logic [3:0]       rx_tick;
    logic [2:0]       rx_bit;
    logic [7:0]       rx_sh;
    logic             rx_extra;
    logic [7:0]       rxd;
    logic             receive_byte_ready;
    logic             pe;
    logic             oe;
    logic             fe;
    logic             brk;
    logic             frame_start_flag;
    logic             ninth;
    logic             matched;
    logic             first;
    logic             irq;
    logic [15:0]      cnt_out;
  } urg_s;
  urg_s st;
  urg_s next_st;

  logic                  tick, tx_go, rx_in, extra_on, done, deliver, tag, isaddr;
  logic                  rd_data, f_in_valid, f_in_ready, f_out_valid;
  logic [urg_pkg::RXW-1:0] f_in, f_out;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = a == off;
  endfunction : hit

  function automatic logic par(input logic [7:0] d, input logic odd);
    par = ^{d, odd};
  endfunction : par

  urg_fifo #(.W(urg_pkg::RXW), .DEPTH(urg_pkg::FIFO_DEPTH)) u_rx_buf (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .in_valid (f_in_valid),
    .in_data  (f_in),
    .in_ready (f_in_ready),
    .out_valid(f_out_valid),
    .out_data (f_out),
    .out_ready(!st.receive_byte_ready)
  );

  assign reg_rdata                = st.rdata;
  assign serial_out_pin           = st.so;
  assign ir_out_pin               = st.iro;
  assign transceiver_drive_output = st.de;
  assign divider_count            = st.cnt_out;
  assign rx_irq_request           = st.irq;

  always_comb begin
    next_st  = st;
    rd_data  = reg_rd && hit(reg_addr, urg_pkg::ADDR_DATA);
    extra_on = st.ctl1[urg_pkg::C1_NINTH_ON] || st.ctl0[urg_pkg::C0_PAR_ON];
    // ------------------------------------------------------------------
    // baud divider
    // ------------------------------------------------------------------
    tick = st.baud_divider <= 16'h0001;
    next_st.baud_divider = tick ? baud_divisor : st.baud_divider - 16'h0001;
    next_st.cnt_out = st.ctl1[urg_pkg::C1_TIMER] ? st.baud_divider : baud_divisor;
    next_st.irq = tick && st.ctl1[urg_pkg::C1_TIMER] && !st.ctl0[urg_pkg::C0_RX_ON];
    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    if (reg_wr) begin
      if (hit(reg_addr, urg_pkg::ADDR_DATA)) begin
        if (st.transmit_holding_empty) begin
          next_st.thold = reg_wdata;
          next_st.transmit_holding_empty = 1'h0;
        end
      end else if (hit(reg_addr, urg_pkg::ADDR_CTL0)) begin
        next_st.ctl0 = reg_wdata;
      end else if (hit(reg_addr, urg_pkg::ADDR_CTL1)) begin
        next_st.ctl1 = reg_wdata;
      end
    end
    // ------------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------------
    tx_go = st.ctl0[urg_pkg::C0_TX_ON] && (!st.ctl0[urg_pkg::C0_FLOW] || !cts_n);
    case (st.tx_state)
      urg_pkg::URG_TX_IDLE: begin
        if (!st.transmit_holding_empty && tx_go) begin
          next_st.transmit_holding_empty = 1'h1;
          next_st.tx_state = urg_pkg::URG_TX_SHIFT;
          next_st.tx_tick = 4'h0;
          next_st.tx_shift = {3'h7, st.thold, 1'h0};
          if (extra_on) begin
            next_st.tx_shift[9] = st.ctl1[urg_pkg::C1_NINTH_ON] ? st.ctl1[urg_pkg::C1_NINTH_TX]
                                : par(st.thold, st.ctl0[urg_pkg::C0_PAR_ODD]);
          end
          next_st.tx_left = urg_pkg::FRAME_MIN + {3'h0, extra_on} + {3'h0, st.ctl0[urg_pkg::C0_STOP2]};
        end
      end
      urg_pkg::URG_TX_SHIFT: begin
        if (tick && tx_go) begin
          next_st.tx_tick = st.tx_tick + 4'h1;
          if (st.tx_tick == urg_pkg::TICK_LAST) begin
            next_st.tx_shift = {1'h1, st.tx_shift[11:1]};
            next_st.tx_left = st.tx_left - 4'h1;
            if (st.tx_left == 4'h0) begin
              next_st.tx_state = urg_pkg::URG_TX_IDLE;
            end
          end
        end
      end
      default: next_st.tx_state = urg_pkg::URG_TX_IDLE;
    endcase
    if (st.ctl0[urg_pkg::C0_BREAK]) begin
      next_st.tx_state = urg_pkg::URG_TX_IDLE;
    end
    next_st.line = st.ctl0[urg_pkg::C0_BREAK] ? 1'h0
                 : (st.tx_state == urg_pkg::URG_TX_SHIFT) ? st.tx_shift[0] : 1'h1;
    next_st.so = st.ctl1[urg_pkg::C1_IR_ON] || st.ctl0[urg_pkg::C0_LOOP] || st.line;
    next_st.iro = st.ctl1[urg_pkg::C1_IR_ON] && !st.ctl0[urg_pkg::C0_LOOP] && !st.line;
    next_st.de = ((st.tx_state == urg_pkg::URG_TX_SHIFT) || !st.transmit_holding_empty) ^ st.ctl1[urg_pkg::C1_DE_POL];
    // ------------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------------
    rx_in = st.ctl0[urg_pkg::C0_LOOP] ? st.line
          : st.ctl1[urg_pkg::C1_IR_ON] ? !ir_in_pin : serial_in_pin;
    done = 1'h0;
    if (tick) begin
      next_st.rx_tick = st.rx_tick + 4'h1;
      case (st.rx_state)
        urg_pkg::URG_RX_IDLE: begin
          next_st.rx_tick = 4'h0;
          if (st.ctl0[urg_pkg::C0_RX_ON] && !rx_in) begin
            next_st.rx_state = urg_pkg::URG_RX_START;
          end
        end
        urg_pkg::URG_RX_START: begin
          if (st.rx_tick == urg_pkg::TICK_MID) begin
            next_st.rx_tick = 4'h0;
            next_st.rx_bit = 3'h0;
            next_st.rx_extra = 1'h0;
            next_st.rx_state = rx_in ? urg_pkg::URG_RX_IDLE : urg_pkg::URG_RX_DATA;
          end
        end
        urg_pkg::URG_RX_DATA: begin
          if (st.rx_tick == urg_pkg::TICK_LAST) begin
            next_st.rx_sh = {rx_in, st.rx_sh[7:1]};
            next_st.rx_bit = st.rx_bit + 3'h1;
            if (st.rx_bit == urg_pkg::BIT_LAST) begin
              next_st.rx_state = extra_on ? urg_pkg::URG_RX_EXTRA : urg_pkg::URG_RX_STOP;
            end
          end
        end
        urg_pkg::URG_RX_EXTRA: begin
          if (st.rx_tick == urg_pkg::TICK_LAST) begin
            next_st.rx_extra = rx_in;
            next_st.rx_state = urg_pkg::URG_RX_STOP;
          end
        end
        urg_pkg::URG_RX_STOP: begin
          if (st.rx_tick == urg_pkg::TICK_LAST) begin
            done = 1'h1;
            next_st.rx_state = urg_pkg::URG_RX_IDLE;
          end
        end
        default: next_st.rx_state = urg_pkg::URG_RX_IDLE;
      endcase
    end
    // ------------------------------------------------------------------
    // address filter and buffer entry
    // ------------------------------------------------------------------
    isaddr = st.ctl1[urg_pkg::C1_NINTH_ON] && st.rx_extra;
    deliver = 1'h1;
    tag = 1'h1;
    f_in = '0;
    if (st.ctl1[urg_pkg::C1_NINTH_ON]) begin
      if (!st.ctl1[urg_pkg::C1_MODE_HI]) begin
        tag = !st.ctl1[urg_pkg::C1_MODE_LO] || isaddr;
      end else if (isaddr) begin
        deliver = (st.rx_sh == node_address) && !st.ctl1[urg_pkg::C1_MODE_LO];
        tag = deliver;
        if (done) begin
          next_st.matched = st.rx_sh == node_address;
          next_st.first = st.rx_sh == node_address;
        end
      end else begin
        deliver = st.matched;
        tag = st.matched;
        f_in[urg_pkg::W_FRAME_START_FLAG] = st.first;
        if (done && deliver) begin
          next_st.first = 1'h0;
        end
      end
    end
    f_in[7:0] = st.rx_sh;
    f_in[urg_pkg::W_NINTH] = isaddr;
    f_in[urg_pkg::W_PE] = st.ctl0[urg_pkg::C0_PAR_ON] && !st.ctl1[urg_pkg::C1_NINTH_ON]
                        && par({st.rx_sh[7:1], st.rx_sh[0] ^ st.rx_extra}, st.ctl0[urg_pkg::C0_PAR_ODD]);
    f_in[urg_pkg::W_FE] = !rx_in;
    f_in[urg_pkg::W_BRK] = (st.rx_sh == 8'h00) && !st.rx_extra && !rx_in;
    f_in[urg_pkg::W_IRQ] = tag;
    f_in_valid = done && deliver;
    // ------------------------------------------------------------------
    // receive holding register and flags
    // ------------------------------------------------------------------
    if (rd_data) begin
      next_st.receive_byte_ready = 1'h0;
      next_st.pe = 1'h0;
      next_st.fe = 1'h0;
      next_st.brk = 1'h0;
      next_st.frame_start_flag = 1'h0;
      next_st.ninth = 1'h0;
      if (!st.receive_byte_ready) begin
        next_st.oe = 1'h0;
      end
    end
    if (f_in_valid && !f_in_ready) begin
      next_st.oe = 1'h1;
      next_st.irq = 1'h1;
    end
    if (f_out_valid && !st.receive_byte_ready) begin
      next_st.rxd = f_out[7:0];
      next_st.receive_byte_ready = 1'h1;
      next_st.pe = f_out[urg_pkg::W_PE];
      next_st.fe = f_out[urg_pkg::W_FE];
      next_st.brk = f_out[urg_pkg::W_BRK];
      next_st.frame_start_flag = f_out[urg_pkg::W_FRAME_START_FLAG];
      next_st.ninth = f_out[urg_pkg::W_NINTH];
      next_st.irq = (f_out[urg_pkg::W_IRQ] && !st.ctl1[urg_pkg::C1_MASK])
                  || f_out[urg_pkg::W_PE] || f_out[urg_pkg::W_FE] || f_out[urg_pkg::W_BRK];
    end
    // ------------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------------
    if (reg_rd) begin
      if (rd_data) begin
        next_st.rdata = st.rxd;
      end else if (hit(reg_addr, urg_pkg::ADDR_STAT0)) begin
        next_st.rdata = {st.receive_byte_ready, st.pe, st.oe, st.fe, st.brk, st.transmit_holding_empty,
                         st.transmit_holding_empty && (st.tx_state == urg_pkg::URG_TX_IDLE), cts_n};
      end else if (hit(reg_addr, urg_pkg::ADDR_CTL0)) begin
        next_st.rdata = st.ctl0;
      end else if (hit(reg_addr, urg_pkg::ADDR_CTL1)) begin
        next_st.rdata = st.ctl1;
      end else if (hit(reg_addr, urg_pkg::ADDR_STAT1)) begin
        next_st.rdata = {6'h00, st.frame_start_flag, st.ninth};
      end else begin
        next_st.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.ctl0 <= urg_pkg::CTL_RESET;
      st.ctl1 <= urg_pkg::CTL_RESET;
      st.transmit_holding_empty <= 1'h1;
      st.line <= 1'h1;
      st.so <= 1'h1;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_read_clears_ready;
    rd_data && st.receive_byte_ready |=> !st.receive_byte_ready ##1 (st.receive_byte_ready || !$past(f_out_valid));
  endproperty
  a_read_clears_ready: assert property (p_read_clears_ready) else $error("ready not cleared");

  property p_write_clears_empty;
    reg_wr && hit(reg_addr, urg_pkg::ADDR_DATA) && st.transmit_holding_empty |=> !st.transmit_holding_empty && st.thold == $past(reg_wdata);
  endproperty
  a_write_clears_empty: assert property (p_write_clears_empty) else $error("empty flag kept");

  property p_overrun_kept;
    st.oe && rd_data && st.receive_byte_ready |=> st.oe;
  endproperty
  a_overrun_kept: assert property (p_overrun_kept) else $error("overrun lost");

  property p_break_low;
    st.ctl0[urg_pkg::C0_BREAK] && !st.ctl0[urg_pkg::C0_LOOP] && !st.ctl1[urg_pkg::C1_IR_ON]
      |=> ##1 !serial_out_pin;
  endproperty
  a_break_low: assert property (p_break_low) else $error("break not driven");

  property p_tx_off_idle;
    !st.ctl0[urg_pkg::C0_TX_ON] && st.tx_state == urg_pkg::URG_TX_IDLE |=> st.tx_state == urg_pkg::URG_TX_IDLE;
  endproperty
  a_tx_off_idle: assert property (p_tx_off_idle) else $error("disabled transmitter started");

  property p_cts_holds;
    st.ctl0[urg_pkg::C0_FLOW] && cts_n && st.tx_state == urg_pkg::URG_TX_SHIFT
      |=> $stable(st.tx_tick) && $stable(st.tx_shift);
  endproperty
  a_cts_holds: assert property (p_cts_holds) else $error("shifted without clear-to-send");

  property p_busy_status;
    reg_rd && hit(reg_addr, urg_pkg::ADDR_STAT0) && st.tx_state == urg_pkg::URG_TX_SHIFT |=> !reg_rdata[1];
  endproperty
  a_busy_status: assert property (p_busy_status) else $error("idle shown while busy");

  property p_de_pol;
    st.tx_state == urg_pkg::URG_TX_SHIFT && !st.ctl1[urg_pkg::C1_DE_POL] |=> transceiver_drive_output;
  endproperty
  a_de_pol: assert property (p_de_pol) else $error("driver enable wrong");

  property p_load_flags;
    f_out_valid && !st.receive_byte_ready |=> st.receive_byte_ready && st.ninth == $past(f_out[urg_pkg::W_NINTH]) && st.rxd == $past(f_out[7:0]);
  endproperty
  a_load_flags: assert property (p_load_flags) else $error("holding load wrong");

  c_tx_frame: cover property (st.tx_state == urg_pkg::URG_TX_IDLE ##1 st.tx_state == urg_pkg::URG_TX_SHIFT);
  c_rx_load: cover property (!st.receive_byte_ready ##1 st.receive_byte_ready);
  c_overrun: cover property (!st.oe ##1 st.oe);
  c_break: cover property (st.brk);
endmodule : urg_uart

// *** dv/urg_node.sv ***
/*
  remote serial node: sends frames into the port and captures its output.
  assumes a 16-cycle bit time and stimulus on the falling clock edge.
*/
`timescale 1ns/1ps

module urg_node #(
  parameter int BIT_CYC = 16
) (
  input  wire logic sys_clk,
  input  wire logic serial_out_pin,
  output logic      serial_in_pin
);
  // ------------------------------------------------------------------
  // frame sender and capture
  // ------------------------------------------------------------------
  initial serial_in_pin = 1'b1;

  task automatic send(input logic [7:0] d, input logic has_x, input logic x, input logic stp);
    logic [10:0] f;
    f = {stp, x, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || has_x) begin
        @(negedge sys_clk);
        serial_in_pin = f[i];
        repeat (BIT_CYC - 1) @(negedge sys_clk);
      end
    end
    @(negedge sys_clk);
    serial_in_pin = 1'b1;
  endtask : send

  task automatic get(output logic [7:0] d);
    @(negedge serial_out_pin);
    repeat (BIT_CYC / 2) @(negedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(negedge sys_clk);
      d[i] = serial_out_pin;
    end
  endtask : get
endmodule : urg_node

// *** dv/testbench.sv ***
/*
  self-checking bench of the serial port register block.
  assumes the remote node model and divisor 1 (16-cycle bits).
*/
`timescale 1ns/1ps

module testbench;
  localparam logic [11:0] A_DAT = urg_pkg::ADDR_DATA;
  localparam logic [11:0] A_S0  = urg_pkg::ADDR_STAT0;
  localparam logic [11:0] A_S1  = urg_pkg::ADDR_STAT1;
  logic        sys_clk;
  logic        arst_n;
  logic [11:0] reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        serial_in_pin;
  logic        serial_out_pin;
  logic        cts_n;
  logic        de_out;
  int          n_errors;
  int          total_checks;
  logic        ir_out;
  logic        irq;
  logic [15:0] div;
  logic [15:0] div_cnt;
  int          n_irq = 0;

  urg_uart u_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .cts_n(cts_n), .ir_in_pin(1'b0), .ir_out_pin(ir_out),
    .transceiver_drive_output(de_out), .baud_divisor(div), .node_address(8'h5a),
    .divider_count(div_cnt), .rx_irq_request(irq)
  );
  urg_node u_node (.sys_clk(sys_clk), .serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin));

  // counts receive interrupt pulses
  always @(posedge sys_clk) begin
    if (irq) n_irq <= n_irq + 1;
  end

  // ------------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    d      = reg_rdata;
  endtask : rd

  task automatic cfg(input logic [7:0] c0, input logic [7:0] c1);
    wr(urg_pkg::ADDR_CTL0, 8'h00);
    wr(urg_pkg::ADDR_CTL1, c1);
    wr(urg_pkg::ADDR_CTL0, c0);
  endtask : cfg

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] v;
    rd(urg_pkg::ADDR_CTL0, v); check(v, 8'h00);
    rd(urg_pkg::ADDR_CTL1, v); check(v, 8'h00);
    rd(A_S1, v); check(v, 8'h00);
    rd(A_S0, v); check(v, 8'h07);
    rd(12'hf45, v); check(v, 8'h00);
    cts_n = 1'b0;
    rd(A_S0, v); check(v, 8'h06);
    $display("test reset done");
  endtask : t_reset

  task automatic t_tx;
    logic [7:0] b;
    logic [7:0] v;
    cfg(8'h80, 8'h00);
    fork
      u_node.get(b);
      begin
        wr(A_DAT, 8'ha5);
        repeat (8) @(negedge sys_clk);
        rd(A_S0, v);
        check(v & 8'h02, 8'h00);
      end
    join
    check(b, 8'ha5);
    repeat (40) @(negedge sys_clk);
    rd(A_S0, v); check(v & 8'h06, 8'h06);
    $display("test transmit done");
  endtask : t_tx

  task automatic t_rx(input logic [7:0] d, input logic [7:0] c0, input logic [7:0] c1, input logic lp,
                      input logic has_x, input logic x, input logic stp, input logic [7:0] e0,
                      input logic [7:0] e1, input logic [7:0] ei);
    logic [7:0] v;
    int         n0;
    n0 = n_irq;
    cfg(c0, c1);
    if (lp) wr(A_DAT, d);
    else u_node.send(d, has_x, x, stp);
    repeat (200) begin
      rd(A_S0, v);
      if (v[7] === 1'b1) break;
    end
    check(v & 8'hf8, e0);
    rd(A_S1, v); check(v, e1);
    rd(A_DAT, v); check(v, d);
    rd(A_S0, v); check(v & 8'hd8, 8'h00);
    rd(A_S1, v); check(v, 8'h00);
    check(8'(n_irq - n0), ei);
    $display("test receive %h done", d);
  endtask : t_rx

  task automatic t_overrun;
    logic [7:0] v;
    cfg(8'h40, 8'h00);
    repeat (10) u_node.send(8'h11, 1'b0, 1'b0, 1'b1);
    rd(A_S0, v); check(v & 8'hf8, 8'ha0);
    repeat (9) rd(A_DAT, v);
    check(v, 8'h11);
    rd(A_S0, v); check(v & 8'ha0, 8'h20);
    rd(A_DAT, v);
    rd(A_S0, v); check(v & 8'ha0, 8'h00);
    $display("test overrun done");
  endtask : t_overrun

  task automatic t_flow;
    logic [7:0] v;
    cts_n = 1'b1;
    cfg(8'ha0, 8'h00);
    wr(A_DAT, 8'h55);
    repeat (20) @(negedge sys_clk);
    rd(A_S0, v); check(v & 8'h06, 8'h00);
    cts_n = 1'b0;
    repeat (30) @(negedge sys_clk);
    cts_n = 1'b1;
    repeat (100) @(negedge sys_clk);
    rd(A_S0, v); check(v & 8'h06, 8'h04);
    cts_n = 1'b0;
    repeat (200) @(negedge sys_clk);
    rd(A_S0, v); check(v & 8'h06, 8'h06);
    $display("test flow control done");
  endtask : t_flow

  task automatic t_timer;
    int n0;
    div = 16'h0005;
    cfg(8'h00, 8'h00);
    check(div_cnt[7:0], 8'h05);
    cfg(8'h00, 8'h04);
    repeat (10) @(negedge sys_clk);
    n0 = n_irq;
    repeat (50) @(negedge sys_clk);
    check(8'(n_irq - n0), 8'h0a);
    div = 16'h0001;
    cfg(8'h00, 8'h00);
    $display("test timer done");
  endtask : t_timer

  task automatic t_pins;
    logic [7:0] v;
    cfg(8'h00, 8'h08);
    rd(urg_pkg::ADDR_CTL1, v); check(v, 8'h08);
    check({7'h00, de_out}, 8'h01);
    cfg(8'h00, 8'h00);
    repeat (2) @(negedge sys_clk);
    check({7'h00, de_out}, 8'h00);
    cfg(8'h84, 8'h00);
    repeat (4) @(negedge sys_clk);
    check({7'h00, serial_out_pin}, 8'h00);
    cfg(8'h84, 8'h01);
    repeat (4) @(negedge sys_clk);
    check({6'h00, ir_out, serial_out_pin}, 8'h03);
    cfg(8'h00, 8'h00);
    repeat (4) @(negedge sys_clk);
    check({7'h00, serial_out_pin}, 8'h01);
    $display("test pins done");
  endtask : t_pins

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------------
  // clock, sequence, watchdog
  // ------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    arst_n = 1'b0;
    reg_addr = 12'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    cts_n = 1'b1;
    div = 16'h0001;
    n_errors = 0;
    total_checks = 0;
    repeat (12) @(negedge sys_clk);
    arst_n = 1'b1;
    t_reset;
    t_tx;
    t_flow;
    t_rx(8'h3c, 8'h40, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 8'h80, 8'h00, 8'h01);
    t_rx(8'h3c, 8'h50, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1, 8'h80, 8'h00, 8'h01);
    t_rx(8'h3c, 8'h58, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1, 8'h80, 8'h00, 8'h01);
    t_rx(8'h3c, 8'h50, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1, 8'hc0, 8'h00, 8'h01);
    t_rx(8'h5a, 8'h40, 8'h40, 1'b0, 1'b1, 1'b1, 1'b1, 8'h80, 8'h01, 8'h01);
    t_rx(8'h00, 8'h40, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 8'h98, 8'h00, 8'h01);
    t_rx(8'h96, 8'hc1, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1, 8'h80, 8'h00, 8'h01);
    t_rx(8'h3c, 8'h40, 8'h02, 1'b0, 1'b0, 1'b0, 1'b1, 8'h80, 8'h00, 8'h00);
    t_rx(8'h00, 8'h40, 8'h02, 1'b0, 1'b0, 1'b0, 1'b0, 8'h98, 8'h00, 8'h01);
    t_rx(8'h5a, 8'h40, 8'hc0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h80, 8'h01, 8'h01);
    t_rx(8'h33, 8'h40, 8'hc0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h80, 8'h02, 8'h01);
    t_overrun;
    t_timer;
    t_pins;
    report_and_stop;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    report_and_stop;
  end
endmodule : testbench
